// [hw/tma_pkg.sv]
package tma_pkg;
    // ----------------------------------------
    // memory geometry and codes
    // ----------------------------------------
    localparam int unsigned TMA_NPTS = 16;
    localparam int unsigned TMA_AW = 4;
    localparam int unsigned TMA_DW = 12;
    localparam logic [11:0] TMA_MID = 12'h800;
    localparam logic [11:0] TMA_TOP = 12'hfff;
    localparam logic [11:0] TMA_CLEAR = 12'h000;
    localparam int unsigned TMA_NPARAM = 8;
    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] TMA_CTRL = 8'h00;
    localparam logic [7:0] TMA_CMD = 8'h04;
    localparam logic [7:0] TMA_LINE = 8'h08;
    localparam logic [7:0] TMA_STAT = 8'h0c;
    localparam logic [7:0] TMA_RDA = 8'h10;
    localparam logic [7:0] TMA_RDB = 8'h14;
    localparam logic [7:0] TMA_REL = 8'h18;
    localparam logic [7:0] TMA_PSEL = 8'h1c;
    // ctrl bits
    localparam int unsigned TMA_C_PEAK = 0;
    localparam int unsigned TMA_C_DIFF = 1;
    localparam int unsigned TMA_C_VA = 2;
    localparam int unsigned TMA_C_VB = 3;
    localparam int unsigned TMA_C_LINE = 4;
    localparam int unsigned TMA_C_SHREF = 5;
    localparam int unsigned TMA_C_NOISE = 6;
    // cmd bits (write one, self clearing)
    localparam int unsigned TMA_K_STORE = 0;
    localparam int unsigned TMA_K_RECALL = 1;
    localparam int unsigned TMA_K_CLEAR = 2;
    localparam int unsigned TMA_K_PARAM = 3;
    // rel bits: [0]=ref on diff, [1]=meas on diff, [2]=request
    localparam logic [1:0] TMA_RESP_OK = 2'b00;
    localparam logic [1:0] TMA_RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        TMA_IDLE = 3'b000,
        TMA_SUB = 3'b001,
        TMA_ADD = 3'b011,
        TMA_COPY = 3'b010,
        TMA_RECALL = 3'b110,
        TMA_CLR = 3'b111
    } tma_state_t;

    typedef struct packed {
        logic valid;
        logic [3:0] addr;
        logic [11:0] data;
    } tma_sample_t;

    typedef struct packed {
        logic valid;
        logic [3:0] addr;
        logic [11:0] data;
        logic [11:0] refl;
    } tma_pixel_t;
endpackage : tma_pkg

// [hw/tma_trace_memory.sv]
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
// Functional notes
// - peak retain keeps largest sample per point outside diff mode
// - diff on subtracts stored trace once
// - diff mode subtracts stored from new samples
// - zero difference shown at middle line
// - shifted command moves zero to level line
// - equal traces flat; positive means current larger
// - diff runs always; drawn only if enabled
// - raw and diff never shown; stored independent
// - diff off adds stored trace back
// - out of range difference saturates in memory; only clipped new samples are counted in status
// - store in diff mode copies diff trace
// - store while idle leaves current unchanged
// - counter reading uses raw current sample
// - noise density blocked in diff mode
// - level line reported from top line in diff mode, on display A only
// - relative in diff mode only when both on diff
// - parameter change touches current data only
// - eight parameter readouts, selected one bright
// - stored memory changed only by copy (store)
module tma_trace_memory (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // video samples
    input wire tma_pkg::tma_sample_t sample_in,
    input wire logic sweeping,
    // display refresh
    input wire logic [3:0] disp_addr,
    output tma_pkg::tma_pixel_t disp_a,
    output tma_pkg::tma_pixel_t disp_b,
    // readouts
    output logic [11:0] counter_level,
    output logic noise_density_readout,
    output logic [7:0] param_bright
);
    import tma_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [11:0] mem_a_q [TMA_NPTS];
    logic [11:0] mem_b_q [TMA_NPTS];
    logic [6:0] ctrl_q;
    logic [11:0] line_q;
    logic [11:0] zero_ref_q;
    logic [2:0] rel_q;
    logic rel_ok_q;
    logic [2:0] psel_q;
    logic param_evt_q;
    logic [3:0] cmd_q;
    tma_state_t state_q;
    logic [3:0] idx_q;
    logic [3:0] rd_idx_q;
    logic [11:0] ovf_q;

    logic diff_on;
    assign diff_on = ctrl_q[TMA_C_DIFF];

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    logic [7:0] aw_q;
    logic aw_have_q;
    logic [31:0] w_q;
    logic w_have_q;
    logic wr_go;
    logic wr_hit;
    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

    always_comb
    begin
        case (aw_q)
            TMA_CTRL, TMA_CMD, TMA_LINE, TMA_REL, TMA_PSEL, TMA_RDA, TMA_RDB: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= 8'h00;
            w_q <= 32'h0000_0000;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= TMA_RESP_OK;
        end
        else
        begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                w_q <= s_axi_wdata;
            end
            if (wr_go)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? TMA_RESP_OK : TMA_RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic [31:0] rd_word;
    logic rd_hit;
    always_comb
    begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            TMA_CTRL: rd_word = {25'h0, ctrl_q};
            TMA_LINE: rd_word = {20'h0, line_q};
            TMA_STAT: rd_word = {13'h0, ovf_q, state_q, idx_q};
            TMA_RDA: rd_word = {20'h0, mem_a_q[rd_idx_q]};
            TMA_RDB: rd_word = {20'h0, mem_b_q[rd_idx_q]};
            TMA_REL: rd_word = {28'h0, rel_ok_q, rel_q};
            TMA_PSEL: rd_word = {29'h0, psel_q};
            TMA_CMD: rd_word = 32'h0000_0000;
            default:
            begin
                rd_word = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= TMA_RESP_OK;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? TMA_RESP_OK : TMA_RESP_SLVERR;
            end
            else if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    logic [6:0] ctrl_wr;
    always_comb
    begin
        ctrl_wr = w_q[6:0];
        ctrl_wr[TMA_C_NOISE] = w_q[TMA_C_NOISE] && !w_q[TMA_C_DIFF];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q <= 7'h04;
            line_q <= TMA_MID;
            zero_ref_q <= TMA_MID;
            rel_q <= 3'h0;
            rel_ok_q <= 1'b0;
            psel_q <= 3'h0;
            cmd_q <= 4'h0;
            rd_idx_q <= 4'h0;
            param_evt_q <= 1'b0;
        end
        else
        begin
            cmd_q <= 4'h0;
            param_evt_q <= 1'b0;
            if (wr_go && s_axi_wstrb[0])
            begin
                case (aw_q)
                    TMA_CTRL:
                    begin
                        ctrl_q <= ctrl_wr;
                        if (!w_q[TMA_C_DIFF])
                        begin
                            zero_ref_q <= TMA_MID;
                        end
                        else if (w_q[TMA_C_SHREF] && w_q[TMA_C_LINE])
                        begin
                            zero_ref_q <= line_q;
                        end
                    end
                    TMA_CMD:
                    begin
                        cmd_q <= w_q[3:0];
                        param_evt_q <= w_q[TMA_K_PARAM];
                    end
                    TMA_LINE: line_q <= w_q[11:0];
                    TMA_REL:
                    begin
                        rel_q <= w_q[2:0];
                        // in diff mode both ends must sit on the difference trace
                        rel_ok_q <= w_q[2] && (!diff_on || (w_q[0] && w_q[1]));
                    end
                    TMA_PSEL: psel_q <= w_q[2:0];
                    TMA_RDA, TMA_RDB: rd_idx_q <= w_q[3:0];
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // trace engine
    // ----------------------------------------
    logic diff_rise;
    logic diff_fall;
    logic diff_d1_q;
    assign diff_rise = diff_on && !diff_d1_q;
    assign diff_fall = !diff_on && diff_d1_q;

    logic [11:0] a_pt;
    logic [11:0] b_pt;
    logic [11:0] s_b;
    logic [11:0] s_a;
    logic [12:0] sub_wide;
    logic [12:0] pt_wide;
    logic [11:0] sub_sat, pt_sat;
    logic sub_clip, pt_clip;
    assign a_pt = mem_a_q[idx_q];
    assign b_pt = mem_b_q[idx_q];
    assign s_b = mem_b_q[sample_in.addr];
    assign s_a = mem_a_q[sample_in.addr];
    // clip to the signed code range: the part lost here is why a restore comes back distorted
    assign sub_wide = {1'b0, sample_in.data} - {1'b0, s_b};
    assign pt_wide = {1'b0, a_pt} - {1'b0, b_pt};
    assign sub_clip = sub_wide[12] != sub_wide[11];
    assign pt_clip = pt_wide[12] != pt_wide[11];
    assign sub_sat = sub_clip ? {sub_wide[12], {11{!sub_wide[12]}}} : sub_wide[11:0];
    assign pt_sat = pt_clip ? {pt_wide[12], {11{!pt_wide[12]}}} : pt_wide[11:0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= TMA_IDLE;
            idx_q <= 4'h0;
            diff_d1_q <= 1'b0;
            ovf_q <= 12'h000;
            for (int i = 0; i < TMA_NPTS; i++)
            begin
                mem_a_q[i] <= TMA_CLEAR;
                mem_b_q[i] <= TMA_CLEAR;
            end
        end
        else
        begin
            case (state_q)
                TMA_IDLE:
                begin
                    idx_q <= 4'h0;
                    if (diff_rise)
                    begin
                        state_q <= TMA_SUB;
                        diff_d1_q <= 1'b1;
                    end
                    else if (diff_fall)
                    begin
                        state_q <= TMA_ADD;
                        diff_d1_q <= 1'b0;
                    end
                    else if (cmd_q[TMA_K_STORE])
                    begin
                        state_q <= TMA_COPY;
                    end
                    else if (cmd_q[TMA_K_RECALL])
                    begin
                        state_q <= TMA_RECALL;
                    end
                    else if (cmd_q[TMA_K_CLEAR])
                    begin
                        state_q <= TMA_CLR;
                    end
                    else if (sample_in.valid)
                    begin
                        // only the current memory takes samples
                        if (diff_on)
                        begin
                            mem_a_q[sample_in.addr] <= sub_sat;
                            ovf_q <= ovf_q + {11'h0, sub_clip};
                        end
                        else if (!ctrl_q[TMA_C_PEAK] || sample_in.data > s_a)
                        begin
                            mem_a_q[sample_in.addr] <= sample_in.data;
                        end
                    end
                end
                TMA_SUB, TMA_ADD, TMA_COPY, TMA_RECALL, TMA_CLR:
                begin
                    case (state_q)
                        TMA_SUB: mem_a_q[idx_q] <= pt_sat;
                        TMA_ADD: mem_a_q[idx_q] <= a_pt + b_pt;
                        TMA_COPY: mem_b_q[idx_q] <= a_pt;
                        TMA_RECALL: mem_a_q[idx_q] <= b_pt;
                        default: mem_a_q[idx_q] <= TMA_CLEAR;
                    endcase
                    idx_q <= idx_q + 4'h1;
                    if (idx_q == 4'(TMA_NPTS - 1))
                    begin
                        state_q <= TMA_IDLE;
                    end
                end
                default: state_q <= TMA_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // display, counter and readouts
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            disp_a <= '0;
            disp_b <= '0;
            counter_level <= 12'h000;
            noise_density_readout <= 1'b0;
            param_bright <= 8'h01;
        end
        else
        begin
            // one memory holds either raw or difference, never both
            disp_a.valid <= ctrl_q[TMA_C_VA];
            disp_a.addr <= disp_addr;
            disp_a.data <= mem_a_q[disp_addr] + (diff_on ? zero_ref_q : 12'h000);
            disp_a.refl <= diff_on ? TMA_TOP - line_q : line_q;
            disp_b.valid <= ctrl_q[TMA_C_VB];
            disp_b.addr <= disp_addr;
            disp_b.data <= mem_b_q[disp_addr];
            disp_b.refl <= line_q;
            if (sample_in.valid && sweeping && !param_evt_q)
            begin
                counter_level <= sample_in.data;
            end
            noise_density_readout <= ctrl_q[TMA_C_NOISE] && !diff_on;
            param_bright <= 8'h01 << psel_q;
        end
    end
endmodule : tma_trace_memory

// [dv/tma_trace_checker.sv]
`timescale 1ns/100ps
module tma_trace_checker (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // samples, display, readouts
    input wire tma_pkg::tma_sample_t sample_in,
    input wire logic sweeping,
    input wire logic [3:0] disp_addr,
    input wire tma_pkg::tma_pixel_t disp_a,
    input wire logic [11:0] counter_level,
    input wire logic [7:0] param_bright
);
    import tma_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer dropped or changed");
    a_aw_answered: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
        else $error("write not answered");
    a_ar_answered: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_bright_onehot: assert property ($onehot(param_bright))
        else $error("brightness not one-hot");
    a_disp_follows: assert property ($past(aresetn) |-> disp_a.addr == $past(disp_addr))
        else $error("refresh point lags");
    a_count_raw: assert property (sweeping && sample_in.valid |=>
        counter_level == $past(sample_in.data)) else $error("counter not raw sample");
    a_count_hold: assert property (!$past(sweeping) |-> $stable(counter_level))
        else $error("counter moved while idle");
endmodule : tma_trace_checker

bind tma_trace_memory tma_trace_checker u_chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sample_in, .sweeping, .disp_addr,
    .disp_a, .counter_level, .param_bright);

// [dv/tma_video_src.sv]
`timescale 1ns/100ps
module tma_video_src (
    // clock
    input wire logic aclk,
    // sample stream and refresh point
    output tma_pkg::tma_sample_t sample_in,
    output logic sweeping,
    output logic [3:0] disp_addr
);
    import tma_pkg::*;
    initial
    begin
        sample_in = '0;
        sweeping = 1'b0;
        disp_addr = 4'h0;
    end
    // payload inverted once valid drops, so a stale value never matches
    task automatic send(input logic [3:0] a, input logic [11:0] d, input logic sw);
        @(posedge aclk);
        sample_in <= '{1'b1, a, d};
        sweeping <= sw;
        @(posedge aclk);
        sample_in <= '{1'b0, ~a, ~d};
        sweeping <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask : send
    task automatic point(input logic [3:0] a);
        @(posedge aclk);
        disp_addr <= a;
        repeat (2) @(posedge aclk);
        #1;
    endtask : point
endmodule : tma_video_src

// [dv/tb_trace_memory_arithmetic.sv]
`timescale 1ns/100ps
module tb_trace_memory_arithmetic;
    import tma_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = '0;
    logic [7:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rv;
    tma_sample_t sample_in;
    logic sweeping, noise_density_readout;
    logic [3:0] disp_addr;
    tma_pixel_t disp_a, disp_b;
    logic [11:0] counter_level;
    logic [7:0] param_bright;
    int n_mismatch = 0;
    int tests_run = 0;

    always #4 aclk = ~aclk;

    tma_trace_memory dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_in, .sweeping, .disp_addr,
        .disp_a, .disp_b, .counter_level, .noise_density_readout, .param_bright);
    tma_video_src src_u (.aclk, .sample_in, .sweeping, .disp_addr);

    // ----
    // bus tasks
    // ----
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(r), 32'(s_axi_bresp));
        // engine passes drop samples for 16 cycles
        repeat (20) @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [1:0] r, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        chk("rresp", 32'(r), 32'(s_axi_rresp));
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'b00);
        rd(a, r, rv);
        chk("rdata", e, rv);
    endtask : rdc
    task automatic mem(input logic [7:0] a, input logic [3:0] i, input logic [11:0] e);
        wr(a, 32'(i));
        rdc(a, 32'(e));
    endtask : mem
    task automatic look(input logic [3:0] i, input logic v, input logic [11:0] e);
        src_u.point(i);
        chk("view", 32'(v), 32'(disp_a.valid));
        if (v) chk("pixel", 32'(e), 32'(disp_a.data));
    endtask : look
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    // ----
    // scenarios
    // ----
    task automatic t_reset();
        chk("bright", 32'h1, 32'(param_bright));
        rdc(TMA_CTRL, 32'h4);
        rdc(TMA_LINE, 32'h800);
        rdc(8'h20, 32'h0, TMA_RESP_SLVERR);
        wr(TMA_STAT, 32'h1, TMA_RESP_SLVERR);
        $display("reset test done");
    endtask : t_reset
    task automatic t_peak();
        wr(TMA_CTRL, 32'h5);
        src_u.send(4'h3, 12'h300, 1'b1);
        src_u.send(4'h3, 12'h400, 1'b1);
        src_u.send(4'h3, 12'h200, 1'b1);
        mem(TMA_RDA, 4'h3, 12'h400);
        chk("count", 32'h200, 32'(counter_level));
        $display("peak test done");
    endtask : t_peak
    task automatic t_diff();
        wr(TMA_CTRL, 32'h4);
        wr(TMA_CMD, 32'h4);
        src_u.send(4'h5, 12'h500, 1'b0);
        wr(TMA_CMD, 32'h1);
        src_u.send(4'h5, 12'h700, 1'b0);
        wr(TMA_CTRL, 32'h6);
        mem(TMA_RDA, 4'h5, 12'h200);
        mem(TMA_RDB, 4'h5, 12'h500);
        look(4'h5, 1'b1, 12'ha00);
        look(4'h6, 1'b1, 12'h800);
        src_u.send(4'h5, 12'h650, 1'b1);
        chk("count", 32'h650, 32'(counter_level));
        look(4'h5, 1'b1, 12'h950);
        wr(TMA_CTRL, 32'ha);
        look(4'h5, 1'b0, 12'h0);
        chk("stored view", 32'h1, 32'(disp_b.valid));
        chk("stored point", 32'h5, 32'(disp_b.addr));
        chk("stored pixel", 32'h500, 32'(disp_b.data));
        src_u.send(4'h5, 12'h520, 1'b0);
        wr(TMA_CTRL, 32'h4);
        mem(TMA_RDA, 4'h5, 12'h520);
        look(4'h5, 1'b1, 12'h520);
        $display("difference test done");
    endtask : t_diff
    task automatic t_shift();
        wr(TMA_LINE, 32'h300);
        wr(TMA_CTRL, 32'h36);
        look(4'h5, 1'b1, 12'h320);
        chk("level", 32'hcff, 32'(disp_a.refl));
        wr(TMA_CTRL, 32'h46);
        chk("noise", 32'h0, 32'(noise_density_readout));
        wr(TMA_CTRL, 32'h44);
        chk("noise", 32'h1, 32'(noise_density_readout));
        chk("level", 32'h300, 32'(disp_a.refl));
        chk("stored level", 32'h300, 32'(disp_b.refl));
        $display("shift test done");
    endtask : t_shift
    task automatic t_store();
        wr(TMA_CTRL, 32'h6);
        wr(TMA_CMD, 32'h1);
        mem(TMA_RDB, 4'h5, 12'h020);
        mem(TMA_RDA, 4'h5, 12'h020);
        src_u.send(4'h5, 12'h400, 1'b1);
        mem(TMA_RDA, 4'h5, 12'h3e0);
        wr(TMA_CMD, 32'h8);
        mem(TMA_RDB, 4'h5, 12'h020);
        wr(TMA_REL, 32'h7);
        rd(TMA_REL, TMA_RESP_OK, rv);
        chk("allow", 32'h1, 32'(rv[3]));
        wr(TMA_REL, 32'h5);
        rd(TMA_REL, TMA_RESP_OK, rv);
        chk("allow", 32'h0, 32'(rv[3]));
        for (int p = 0; p < 8; p++)
        begin
            wr(TMA_PSEL, 32'(p));
            chk("bright", 32'h1 << p, 32'(param_bright));
        end
        $display("store test done");
    endtask : t_store
    task automatic t_ovf();
        src_u.send(4'h7, 12'hf00, 1'b1);
        mem(TMA_RDA, 4'h7, 12'h7ff);
        wr(TMA_CTRL, 32'h4);
        mem(TMA_RDA, 4'h7, 12'h7ff);
        mem(TMA_RDA, 4'h5, 12'h400);
        $display("overflow test done");
    endtask : t_ovf

    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_peak();
        t_diff();
        t_shift();
        t_store();
        t_ovf();
        give_verdict();
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        give_verdict();
    end
endmodule : tb_trace_memory_arithmetic
